/* File: clb_params.svh */
`ifndef CLB_PARAMS_SVH
`define CLB_PARAMS_SVH

// ==========================================================================
// Register map
`define CLB_ADR_CTRL        6'h00
`define CLB_ADR_STATUS      6'h01
`define CLB_ADR_COUNT       6'h02
`define CLB_ADR_ASSURE      6'h03
`define CLB_CTRL_IN_EN      0
`define CLB_CTRL_OUT_EN     1
`define CLB_CTRL_OUT_START  2
`define CLB_CTRL_TO_CLR     3
`define CLB_ST_TIMEOUT      0
`define CLB_ST_HDR_EXP      1
`define CLB_ST_HSQ          2
`define CLB_ST_IN_ACT       3
`define CLB_ST_OUT_ACT      4
`define CLB_ST_IN_IR        5
`define CLB_ST_OUT_IR       6
`define CLB_ST_OUT_OR       7
`define CLB_ST_DMA_LSB      8
`define CLB_COUNT_RST       16'h0003
`define CLB_ASSURE_RST      8'h00

// ==========================================================================
// Crate function codes
`define CLB_FN_READ         5'h00
`define CLB_FN_WRITE        5'h10
`define CLB_FN_HEADER       5'h14
`define CLB_FN_WRITE_ALT    5'h16
`define CLB_HDR_BYTES       3'h4

// ==========================================================================
// Timing
`define CLB_CLK_MHZ         250
`define CLB_TIMEOUT_NS      8000
`define CLB_REQ_GAP_NS      100
`define CLB_TIMEOUT_CYC     ((`CLB_TIMEOUT_NS * `CLB_CLK_MHZ + 999) / 1000)
`define CLB_REQ_GAP_CYC     ((`CLB_REQ_GAP_NS * `CLB_CLK_MHZ + 999) / 1000)

`endif

/* File: clb_pkg.sv */
package clb_pkg;
  typedef enum logic [1:0] {CR_IDLE, CR_LOAD, CR_UNLOAD, CR_REPLY} clb_crate_st_t;
endpackage : clb_pkg

/* File: clb_bridge.sv */
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "clb_params.svh"
module clb_bridge import clb_pkg::*; #(
  parameter int DEPTH       = 64,
  parameter int TIMEOUT_CYC = `CLB_TIMEOUT_CYC,
  parameter int GAP_CYC     = `CLB_REQ_GAP_CYC
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        pb_reset_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Crate side
  input  wire logic        crate_cmd,
  input  wire logic [4:0]  crate_func,
  input  wire logic [23:0] crate_wdata,
  output logic      [23:0] crate_rdata,
  output logic             crate_reply,
  output logic             crate_q,
  // Local bus DMA
  output logic      [1:0]  dma_req,
  input  wire logic [3:0]  dma_ack,
  input  wire logic [1:0]  dma_done,
  input  wire logic        upper_byte_strobe,
  input  wire logic        lower_byte_strobe,
  input  wire logic [15:0] local_rdata,
  output logic      [15:0] local_wdata,
  output logic             swapped_upper_strobe,
  output logic             swapped_lower_strobe,
  // Status
  output logic             transfer_timeout_flag,
  output logic             header_expected_flag,
  output logic             header_sequence_active,
  output logic             inbound_transfer_active,
  output logic             outbound_transfer_active,
  output logic             inbound_fifo_input_ready,
  output logic             outbound_fifo_input_ready,
  output logic             outbound_fifo_output_ready,
  output logic      [3:0]  dma_active
);

  localparam int AW = $clog2(DEPTH);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam int GW = $clog2(GAP_CYC + 1);

  if (DEPTH < 4 || (1 << AW) != DEPTH || TIMEOUT_CYC < 1 || GAP_CYC < 1) begin : g_bad
    $error("clb_bridge: DEPTH must be a power of two >= 4, counts >= 1");
  end

  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] d,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? d[15:8] : old_v[15:8], sel[0] ? d[7:0] : old_v[7:0]};
  endfunction : merge16

  // ========================================================================
  // Pushbutton synchroniser and combined reset
  logic pb_s1_r, pb_s2_r, pb_s3_r;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pb_s1_r <= 1'b1;
      pb_s2_r <= 1'b1;
      pb_s3_r <= 1'b1;
    end else begin
      pb_s1_r <= pb_reset_n;
      pb_s2_r <= pb_s1_r;
      pb_s3_r <= pb_s2_r;
    end
  end
  // Held one extra cycle so a short press still clears everything
  logic clr;
  assign clr = !rst_n || !pb_s2_r || !pb_s3_r;

  // ========================================================================
  // State
  logic [7:0]      in_mem  [DEPTH];
  logic [7:0]      out_mem [DEPTH];
  logic [AW:0]     in_wp_r, in_wp_nxt, in_rp_r, in_rp_nxt;
  logic [AW:0]     out_wp_r, out_wp_nxt, out_rp_r, out_rp_nxt;
  logic            ack_r, ack_nxt;
  logic [31:0]     rdat_r, rdat_nxt;
  logic [1:0]      en_r, en_nxt;
  logic [15:0]     count_r, count_nxt;
  logic [7:0]      assure_r, assure_nxt;
  clb_crate_st_t   cst_r, cst_nxt;
  logic [2:0]      bidx_r, bidx_nxt, blen_r, blen_nxt;
  logic [23:0]     cword_r, cword_nxt;
  logic [TW-1:0]   tmr_r, tmr_nxt;
  logic            qok_r, qok_nxt, reply_r, reply_nxt;
  logic            to_r, to_nxt, hexp_r, hexp_nxt, hsq_r, hsq_nxt;
  logic            inact_r, inact_nxt, outact_r, outact_nxt;
  logic [15:0]     in_cnt_r, in_cnt_nxt;
  logic [1:0]      req_r, req_nxt, ackd_r;
  logic [GW-1:0]   gap0_r, gap0_nxt, gap1_r, gap1_nxt;
  logic [7:0]      inbyte_r, inbyte_nxt, outbyte_r, outbyte_nxt;
  logic            sus_r, sus_nxt, sls_r, sls_nxt;
  logic [3:0]      dact_r, dact_nxt;
  logic [7:0]      in_push_d, out_push_d;
  logic            in_push, in_pop, out_push, out_pop;
  logic            in_full, in_empty, out_full, out_empty;

  always_comb begin
    in_full   = (in_wp_r - in_rp_r) == (AW + 1)'(DEPTH);
    in_empty  = in_wp_r == in_rp_r;
    out_full  = (out_wp_r - out_rp_r) == (AW + 1)'(DEPTH);
    out_empty = out_wp_r == out_rp_r;
  end

  // ========================================================================
  // Next-state logic
  logic wb_hit, wb_wr, cr_start, pair_swap, ack0_rise, ack0_fall, ack1_fall;
  always_comb begin
    wb_hit    = wb_cyc_i && wb_stb_i && !ack_r;
    wb_wr     = wb_hit && wb_we_i;
    ack0_rise = dma_ack[0] && !ackd_r[0];
    ack0_fall = !dma_ack[0] && ackd_r[0];
    ack1_fall = !dma_ack[1] && ackd_r[1];
    ack_nxt   = wb_hit;
    rdat_nxt  = 32'h0000_0000;
    en_nxt    = en_r;
    count_nxt = count_r;
    assure_nxt = assure_r;
    to_nxt    = to_r;
    outact_nxt = outact_r;
    cst_nxt   = cst_r;
    bidx_nxt  = bidx_r;
    blen_nxt  = blen_r;
    cword_nxt = cword_r;
    tmr_nxt   = tmr_r;
    qok_nxt   = qok_r;
    reply_nxt = 1'b0;
    hexp_nxt  = hexp_r;
    hsq_nxt   = hsq_r;
    inact_nxt = inact_r;
    in_cnt_nxt = in_cnt_r;
    req_nxt   = req_r;
    gap0_nxt  = (gap0_r != '0) ? gap0_r - GW'(1) : gap0_r;
    gap1_nxt  = (gap1_r != '0) ? gap1_r - GW'(1) : gap1_r;
    inbyte_nxt = inbyte_r;
    outbyte_nxt = outbyte_r;
    in_push   = 1'b0;
    in_push_d = 8'h00;
    in_pop    = 1'b0;
    out_push  = 1'b0;
    out_push_d = outbyte_r;
    out_pop   = 1'b0;

    // Register bus
    if (wb_hit && !wb_we_i) begin
      unique case (wb_adr_i[7:2])
        `CLB_ADR_CTRL:   rdat_nxt = {30'h0000_0000, en_r};
        `CLB_ADR_STATUS: rdat_nxt = {20'h0_0000, dact_r, out_empty ? 1'b0 : 1'b1,
                                     !out_full, !in_full, outact_r, inact_r, hsq_r,
                                     hexp_r, to_r};
        `CLB_ADR_COUNT:  rdat_nxt = {16'h0000, count_r};
        `CLB_ADR_ASSURE: rdat_nxt = {24'h00_0000, assure_r};
        default:         rdat_nxt = 32'h0000_0000;
      endcase
    end
    if (wb_wr && wb_adr_i[7:2] == `CLB_ADR_CTRL && wb_sel_i[0]) begin
      en_nxt = wb_dat_i[1:0];
      if (wb_dat_i[`CLB_CTRL_OUT_START])
        outact_nxt = 1'b1;
      if (wb_dat_i[`CLB_CTRL_TO_CLR])
        to_nxt = 1'b0;
    end
    // Counts that are not a multiple of three are refused
    if (wb_wr && wb_adr_i[7:2] == `CLB_ADR_COUNT &&
        (merge16(count_r, wb_dat_i, wb_sel_i) % 16'h0003) == 16'h0000)
      count_nxt = merge16(count_r, wb_dat_i, wb_sel_i);
    if (wb_wr && wb_adr_i[7:2] == `CLB_ADR_ASSURE && wb_sel_i[0])
      assure_nxt = wb_dat_i[7:0];

    // Crate transfers through the inbound and outbound FIFOs
    cr_start = 1'b0;
    unique case (cst_r)
      CR_IDLE: begin
        if (crate_cmd) begin
          bidx_nxt  = 3'h0;
          cword_nxt = crate_wdata;
          tmr_nxt   = '0;
          qok_nxt   = 1'b1;
          if (crate_func == `CLB_FN_HEADER) begin
            blen_nxt = `CLB_HDR_BYTES;
            hexp_nxt = 1'b0;
            hsq_nxt  = 1'b1;
            cst_nxt  = CR_LOAD;
          end else if (crate_func == `CLB_FN_WRITE || crate_func == `CLB_FN_WRITE_ALT) begin
            blen_nxt = 3'h3;
            cr_start = !hexp_r && !hsq_r;
            cst_nxt  = CR_LOAD;
          end else if (crate_func == `CLB_FN_READ) begin
            cword_nxt = 24'h00_0000;
            cst_nxt   = CR_UNLOAD;
          end else begin
            cst_nxt = CR_REPLY;
          end
        end
      end
      CR_LOAD: begin
        in_push_d = (bidx_r == 3'h3) ? assure_r : cword_r[8 * bidx_r +: 8];
        if (!in_full) begin
          in_push  = 1'b1;
          tmr_nxt  = '0;
          bidx_nxt = bidx_r + 3'h1;
          if (bidx_r + 3'h1 == blen_r)
            cst_nxt = CR_REPLY;
        end else if (tmr_r == TW'(TIMEOUT_CYC)) begin
          to_nxt  = 1'b1;
          qok_nxt = 1'b0;
          cst_nxt = CR_REPLY;
        end else begin
          tmr_nxt = tmr_r + TW'(1);
        end
      end
      CR_UNLOAD: begin
        if (!out_empty) begin
          out_pop = 1'b1;
          cword_nxt[8 * bidx_r[1:0] +: 8] = out_mem[out_rp_r[AW-1:0]];
          tmr_nxt  = '0;
          bidx_nxt = bidx_r + 3'h1;
          if (bidx_r == 3'h2)
            cst_nxt = CR_REPLY;
        end else if (tmr_r == TW'(TIMEOUT_CYC)) begin
          to_nxt  = 1'b1;
          qok_nxt = 1'b0;
          cst_nxt = CR_REPLY;
        end else begin
          tmr_nxt = tmr_r + TW'(1);
        end
      end
      CR_REPLY: begin
        reply_nxt = 1'b1;
        cst_nxt   = CR_IDLE;
      end
    endcase
    if (cr_start && !inact_r) begin
      inact_nxt  = 1'b1;
      in_cnt_nxt = 16'h0000;
    end

    // Inbound channel: one request per byte, withdrawn on acknowledge
    if (ack0_rise) begin
      req_nxt[0] = 1'b0;
      in_pop     = 1'b1;
      inbyte_nxt = in_mem[in_rp_r[AW-1:0]];
    end else if (!req_r[0] && !dma_ack[0] && en_r[`CLB_CTRL_IN_EN] && gap0_r == '0 &&
                 !in_empty && (hsq_r || inact_r)) begin
      req_nxt[0] = 1'b1;
    end
    if (ack0_fall) begin
      gap0_nxt = GW'(GAP_CYC);
      if (hsq_r) begin
        in_cnt_nxt = in_cnt_r + 16'h0001;
        if (in_cnt_r + 16'h0001 == 16'(`CLB_HDR_BYTES)) begin
          hsq_nxt    = 1'b0;
          in_cnt_nxt = 16'h0000;
        end
      end else if (inact_r) begin
        in_cnt_nxt = in_cnt_r + 16'h0001;
        if (in_cnt_r + 16'h0001 == count_r) begin
          inact_nxt = 1'b0;
          hexp_nxt  = 1'b1;
        end
      end
    end
    if (dma_done[0] && hsq_r && !ack0_fall)
      hsq_nxt = hsq_r;
    // A header arriving as the previous transfer ends must win over its clear
    if (cst_r == CR_IDLE && crate_cmd && crate_func == `CLB_FN_HEADER) begin
      hexp_nxt = 1'b0;
      hsq_nxt  = 1'b1;
    end

    // Outbound channel: byte taken from the swapped lane, pushed as ack falls
    if (dma_ack[1]) begin
      req_nxt[1]  = 1'b0;
      outbyte_nxt = lower_byte_strobe ? local_rdata[15:8] : local_rdata[7:0];
    end else if (!req_r[1] && !ack1_fall && outact_r && en_r[`CLB_CTRL_OUT_EN] &&
                 gap1_r == '0 && !out_full) begin
      req_nxt[1] = 1'b1;
    end
    if (ack1_fall) begin
      out_push = !out_full;
      gap1_nxt = GW'(GAP_CYC);
    end
    if (dma_done[1] && !outact_nxt)
      outact_nxt = 1'b0;
    else if (dma_done[1] && !(wb_wr && wb_adr_i[7:2] == `CLB_ADR_CTRL &&
             wb_sel_i[0] && wb_dat_i[`CLB_CTRL_OUT_START]))
      outact_nxt = 1'b0;

    // Strobes are exchanged only while a crate DMA channel is acknowledged
    pair_swap = dma_ack[0] || dma_ack[1];
    sus_nxt   = pair_swap ? lower_byte_strobe : upper_byte_strobe;
    sls_nxt   = pair_swap ? upper_byte_strobe : lower_byte_strobe;

    for (int i = 0; i < 4; i++)
      dact_nxt[i] = dma_ack[i] || (i < 2 && req_r[i % 2]);
  end

  // Every inbound pair is presented with the same lane swap
  assign in_wp_nxt  = in_wp_r + (AW + 1)'(in_push);
  assign in_rp_nxt  = in_rp_r + (AW + 1)'(in_pop);
  assign out_wp_nxt = out_wp_r + (AW + 1)'(out_push);
  assign out_rp_nxt = out_rp_r + (AW + 1)'(out_pop);

  // ========================================================================
  // Registers
  always_ff @(posedge clock) begin
    if (in_push)
      in_mem[in_wp_r[AW-1:0]] <= in_push_d;
    if (out_push)
      out_mem[out_wp_r[AW-1:0]] <= out_push_d;
  end

  always_ff @(posedge clock) begin
    if (clr) begin
      in_wp_r  <= '0;
      in_rp_r  <= '0;
      out_wp_r <= '0;
      out_rp_r <= '0;
      ack_r    <= 1'b0;
      rdat_r   <= 32'h0000_0000;
      en_r     <= 2'h0;
      count_r  <= `CLB_COUNT_RST;
      assure_r <= `CLB_ASSURE_RST;
      cst_r    <= CR_IDLE;
      bidx_r   <= 3'h0;
      blen_r   <= 3'h0;
      cword_r  <= 24'h00_0000;
      tmr_r    <= '0;
      qok_r    <= 1'b1;
      reply_r  <= 1'b0;
      to_r     <= 1'b0;
      hexp_r   <= 1'b1;
      hsq_r    <= 1'b0;
      inact_r  <= 1'b0;
      outact_r <= 1'b0;
      in_cnt_r <= 16'h0000;
      req_r    <= 2'h0;
      ackd_r   <= 2'h0;
      gap0_r   <= '0;
      gap1_r   <= '0;
      inbyte_r <= 8'h00;
      outbyte_r <= 8'h00;
      sus_r    <= 1'b0;
      sls_r    <= 1'b0;
      dact_r   <= 4'h0;
    end else begin
      in_wp_r  <= in_wp_nxt;
      in_rp_r  <= in_rp_nxt;
      out_wp_r <= out_wp_nxt;
      out_rp_r <= out_rp_nxt;
      ack_r    <= ack_nxt;
      rdat_r   <= rdat_nxt;
      en_r     <= en_nxt;
      count_r  <= count_nxt;
      assure_r <= assure_nxt;
      cst_r    <= cst_nxt;
      bidx_r   <= bidx_nxt;
      blen_r   <= blen_nxt;
      cword_r  <= cword_nxt;
      tmr_r    <= tmr_nxt;
      qok_r    <= qok_nxt;
      reply_r  <= reply_nxt;
      to_r     <= to_nxt;
      hexp_r   <= hexp_nxt;
      hsq_r    <= hsq_nxt;
      inact_r  <= inact_nxt;
      outact_r <= outact_nxt;
      in_cnt_r <= in_cnt_nxt;
      req_r    <= req_nxt;
      ackd_r   <= dma_ack[1:0];
      gap0_r   <= gap0_nxt;
      gap1_r   <= gap1_nxt;
      inbyte_r <= inbyte_nxt;
      outbyte_r <= outbyte_nxt;
      sus_r    <= sus_nxt;
      sls_r    <= sls_nxt;
      dact_r   <= dact_nxt;
    end
  end

  // Status outputs are registered copies; FIFO ready flags lag pointers by one
  logic [2:0] rdy_r;
  always_ff @(posedge clock) begin
    if (clr)
      rdy_r <= 3'h0;
    else
      rdy_r <= {!out_empty, !out_full, !in_full};
  end

  // ========================================================================
  // Outputs
  assign wb_ack_o                  = ack_r;
  assign wb_dat_o                  = rdat_r;
  assign crate_rdata               = cword_r;
  assign crate_reply               = reply_r;
  assign crate_q                   = qok_r;
  assign dma_req                   = req_r;
  assign local_wdata               = {inbyte_r, inbyte_r};
  assign swapped_upper_strobe      = sus_r;
  assign swapped_lower_strobe      = sls_r;
  assign transfer_timeout_flag     = to_r;
  assign header_expected_flag      = hexp_r;
  assign header_sequence_active    = hsq_r;
  assign inbound_transfer_active   = inact_r;
  assign outbound_transfer_active  = outact_r;
  assign inbound_fifo_input_ready  = rdy_r[0];
  assign outbound_fifo_input_ready = rdy_r[1];
  assign outbound_fifo_output_ready = rdy_r[2];
  assign dma_active                = dact_r;

endmodule : clb_bridge
`default_nettype wire

/* File: clb_bridge_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module clb_bridge_properties (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst_n,
  // Watched ports
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_we_i,
  input wire logic       wb_ack_o,
  input wire logic       crate_reply,
  input wire logic [1:0] dma_req,
  input wire logic [3:0] dma_ack,
  input wire logic       upper_byte_strobe,
  input wire logic       lower_byte_strobe,
  input wire logic       swapped_upper_strobe,
  input wire logic       swapped_lower_strobe,
  input wire logic       transfer_timeout_flag,
  input wire logic [3:0] dma_active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========
  // Handshakes
  property p_ack_take; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_take: assert property (p_ack_take) else $error("bus request not answered");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("bus ack longer than one cycle");
  property p_reply_once; crate_reply |=> !crate_reply; endproperty
  a_reply_once: assert property (p_reply_once) else $error("crate reply not a pulse");
  property p_req_drop; dma_ack[0] && dma_req[0] |=> !dma_req[0]; endproperty
  a_req_drop: assert property (p_req_drop) else $error("inbound request kept");
  // Pushing the byte takes the cycle after ack ends, so no request may overlap it
  property p_req_gap; $fell(dma_ack[1]) |-> !dma_req[1] [*2]; endproperty
  a_req_gap: assert property (p_req_gap) else $error("outbound request too early");
  // ==========
  // Strobes and flags
  property p_swap;
    (dma_ack[0] || dma_ack[1]) |=> swapped_upper_strobe == $past(lower_byte_strobe)
      && swapped_lower_strobe == $past(upper_byte_strobe);
  endproperty
  a_swap: assert property (p_swap) else $error("no swap");
  property p_plain;
    !(dma_ack[0] || dma_ack[1]) |=> swapped_upper_strobe == $past(upper_byte_strobe)
      && swapped_lower_strobe == $past(lower_byte_strobe);
  endproperty
  a_plain: assert property (p_plain) else $error("strobes exchanged outside DMA");
  property p_active;
    1'b1 |=> dma_active == {$past(dma_ack[3:2]), $past(dma_ack[1:0] | dma_req)};
  endproperty
  a_active: assert property (p_active) else $error("channel activity wrong");
  property p_to_hold;
    transfer_timeout_flag && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> transfer_timeout_flag;
  endproperty
  a_to_hold: assert property (p_to_hold) else $error("timeout flag lost");
endmodule : clb_bridge_properties
bind clb_bridge clb_bridge_properties u_props (.clock, .rst_n, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_ack_o, .crate_reply, .dma_req, .dma_ack, .upper_byte_strobe,
  .lower_byte_strobe, .swapped_upper_strobe, .swapped_lower_strobe,
  .transfer_timeout_flag, .dma_active);
`default_nettype wire

/* File: clb_crate_model.sv */
`timescale 1ns/1ps
`default_nettype none
module clb_crate_model (
  // Clock
  input  wire logic        clock,
  // Command
  output logic             crate_cmd,
  output logic      [4:0]  crate_func,
  output logic      [23:0] crate_wdata,
  // Answer
  input  wire logic [23:0] crate_rdata,
  input  wire logic        crate_reply,
  input  wire logic        crate_q
);
  initial begin
    crate_cmd   = 1'b0;
    crate_func  = 5'h00;
    crate_wdata = 24'h00_0000;
  end
  // One command, then wait for its reply before anything else goes out
  task automatic issue(input logic [4:0] f, input logic [23:0] d,
                       output logic [23:0] rd, output logic q);
    int n;
    n = 0;
    q = 1'bx;
    crate_cmd   <= 1'b1;
    crate_func  <= f;
    crate_wdata <= d;
    @(posedge clock);
    crate_cmd   <= 1'b0;
    // Released lines show the inverse so a stale word cannot pass
    crate_wdata <= ~d;
    do @(posedge clock); while (crate_reply !== 1'b1 && ++n < 400);
    rd = crate_rdata;
    if (n < 400) q = crate_q;
  endtask : issue
endmodule : clb_crate_model
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "clb_params.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: got %0h, expected %0h", $time, (a), (b)); end end
module tb import clb_pkg::*;;
  logic        clock, rst_n, pb_reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, dma_ack, dma_active;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        crate_cmd, crate_reply, crate_q, cq;
  logic [4:0]  crate_func;
  logic [23:0] crate_wdata, crate_rdata, crd, wd;
  logic [1:0]  dma_req, dma_done;
  logic        upper_byte_strobe, lower_byte_strobe, swapped_upper_strobe;
  logic        swapped_lower_strobe, transfer_timeout_flag, header_expected_flag;
  logic        header_sequence_active, inbound_transfer_active, outbound_transfer_active;
  logic        inbound_fifo_input_ready, outbound_fifo_input_ready;
  logic        outbound_fifo_output_ready;
  logic [15:0] local_rdata, local_wdata;
  int          n_mismatch, checked;
  // Small depth and counts keep full-FIFO and timeout cases short
  clb_bridge #(.DEPTH(4), .TIMEOUT_CYC(20), .GAP_CYC(4)) u_dut (.clock, .rst_n,
    .pb_reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .crate_cmd, .crate_func, .crate_wdata, .crate_rdata,
    .crate_reply, .crate_q, .dma_req, .dma_ack, .dma_done, .upper_byte_strobe,
    .lower_byte_strobe, .local_rdata, .local_wdata, .swapped_upper_strobe,
    .swapped_lower_strobe, .transfer_timeout_flag, .header_expected_flag,
    .header_sequence_active, .inbound_transfer_active, .outbound_transfer_active,
    .inbound_fifo_input_ready, .outbound_fifo_input_ready,
    .outbound_fifo_output_ready, .dma_active);
  clb_crate_model u_crate (.clock, .crate_cmd, .crate_func, .crate_wdata,
    .crate_rdata, .crate_reply, .crate_q);
  always #2 clock = ~clock;
  // ==========
  // Access tasks
  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {a, 2'b00};
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do @(posedge clock); while (wb_ack_o !== 1'b1 && ++n < 50);
    // A bus that never answers counts as a failure, not a silent skip
    if (n >= 50) n_mismatch++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask : wb
  // Local DMA controller: one acknowledge per request, byte on the lane opposite the one it strobes
  task automatic dma(input int ch, input logic [7:0] b, input logic odd);
    int n;
    n = 0;
    do @(posedge clock); while (dma_req[ch] !== 1'b1 && ++n < 200);
    if (n >= 200) n_mismatch++;
    dma_ack[ch]       <= 1'b1;
    upper_byte_strobe <= !odd;
    lower_byte_strobe <= odd;
    local_rdata       <= odd ? {b, ~b} : {~b, b};
    repeat (2) @(posedge clock);
    `CHK({swapped_upper_strobe, swapped_lower_strobe}, {odd, !odd});
    if (ch == 0) `CHK(local_wdata, {b, b});
    dma_ack[ch]       <= 1'b0;
    upper_byte_strobe <= 1'b0;
    lower_byte_strobe <= 1'b0;
    local_rdata       <= ~local_rdata;
  endtask : dma
  task automatic report_and_stop();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    report_and_stop();
  end
  // ==========
  // Tests
  initial begin
    {clock, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, upper_byte_strobe, lower_byte_strobe} = '0;
    {wb_adr_i, wb_dat_i, dma_ack, dma_done, n_mismatch, checked} = '0;
    pb_reset_n  = 1'b1;
    wb_sel_i    = 4'hf;
    local_rdata = 16'h5a5a;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    `CHK({header_expected_flag, crate_q, header_sequence_active}, 3'b110);
    wb(1'b0, `CLB_ADR_ASSURE, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000);
    wb(1'b0, 6'h2a, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000);
    wb(1'b1, `CLB_ADR_COUNT, 32'h0000_0004);
    wb(1'b0, `CLB_ADR_COUNT, 32'h0000_0000);
    `CHK(rd, 32'h0000_0003);
    `CHK({inbound_fifo_input_ready, outbound_fifo_input_ready,
          outbound_fifo_output_ready}, 3'b110);
    wb(1'b1, `CLB_ADR_ASSURE, 32'h0000_00a5);
    wb(1'b1, `CLB_ADR_CTRL, 32'h0000_0001);
    u_crate.issue(`CLB_FN_HEADER, 24'h33_2211, crd, cq);
    `CHK({cq, header_sequence_active, header_expected_flag}, 3'b110);
    for (int i = 0; i < 4; i++) dma(0, 8'(32'ha533_2211 >> (8 * i)), i[0]);
    repeat (10) @(posedge clock);
    `CHK({header_sequence_active, dma_req[0]}, 2'b00);
    wb(1'b1, `CLB_ADR_COUNT, 32'h0000_0006);
    for (int j = 0; j < 2; j++) begin
      wd = j[0] ? 24'h99_8877 : 24'h66_5544;
      u_crate.issue(j[0] ? `CLB_FN_WRITE_ALT : `CLB_FN_WRITE, wd, crd, cq);
      `CHK({inbound_transfer_active, cq}, 2'b11);
      for (int i = 0; i < 3; i++) dma(0, wd[8*i +: 8], i[0]);
    end
    repeat (3) @(posedge clock);
    `CHK({inbound_transfer_active, header_expected_flag}, 2'b01);
    wb(1'b1, `CLB_ADR_CTRL, 32'h0000_0007);
    repeat (2) @(posedge clock);
    `CHK(outbound_transfer_active, 1'b1);
    for (int i = 0; i < 4; i++) dma(1, 8'(32'hddcc_bbaa >> (8 * i)), i[0]);
    repeat (8) @(posedge clock);
    `CHK({outbound_fifo_input_ready, dma_req[1], outbound_fifo_output_ready},
         3'b001);
    dma_done[1] <= 1'b1;
    dma_ack[2]  <= 1'b1;
    @(posedge clock);
    dma_done[1] <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK({outbound_transfer_active, dma_active[2]}, 2'b01);
    dma_ack[2] <= 1'b0;
    u_crate.issue(`CLB_FN_READ, 24'h00_0000, crd, cq);
    `CHK({crd, cq}, {24'hcc_bbaa, 1'b1});
    u_crate.issue(`CLB_FN_READ, 24'h00_0000, crd, cq);
    wb(1'b0, `CLB_ADR_STATUS, 32'h0000_0000);
    `CHK({cq, transfer_timeout_flag, rd[0]}, 3'b011);
    wb(1'b1, `CLB_ADR_CTRL, 32'h0000_0008);
    wb(1'b0, `CLB_ADR_STATUS, 32'h0000_0000);
    `CHK(rd[0], 1'b0);
    u_crate.issue(`CLB_FN_HEADER, 24'h12_3456, crd, cq);
    repeat (2) @(posedge clock);
    `CHK({inbound_fifo_input_ready, header_sequence_active, cq}, 3'b011);
    pb_reset_n <= 1'b0;
    @(posedge clock);
    pb_reset_n <= 1'b1;
    repeat (6) @(posedge clock);
    `CHK({header_expected_flag, header_sequence_active, inbound_fifo_input_ready},
         3'b101);
    wb(1'b0, `CLB_ADR_COUNT, 32'h0000_0000);
    `CHK(rd, 32'h0000_0003);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
